/* rtl/power_reset_pkg.sv */
// Constants shared by the power-control and reset-source block.
// Assumes a 32-bit AXI4-Lite master; register indices are word indices (byte address = 4 x index).
package power_reset_pkg;

  // ****************************************************************
  // Bus geometry and register indices
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_PERIPH_POWER = 8'hb5;
  localparam logic [7:0] IDX_RESET_SOURCE = 8'hdf;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'hf0;
  localparam logic [7:0] IDX_USER_CONFIG = 8'hf1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PC_MODE_LO = 0;
  localparam int PC_MODE_HI = 1;
  localparam int PC_FLAG_LO = 2;
  localparam int PC_FLAG_HI = 3;
  localparam int PC_BOD_IRQ_SEL = 4;
  localparam int PC_BOD_OFF = 5;
  localparam int PC_FE_SEL = 6;
  localparam int PC_DOUBLE_RATE = 7;
  localparam int PP_SERIAL_OFF = 1;
  localparam int PP_CONVERTER_OFF = 4;
  localparam int PP_COMPARATOR_OFF = 5;
  localparam int PP_RTC_OFF = 7;
  localparam logic [7:0] PP_WRITABLE = 8'hb2;
  localparam int RS_EXTERNAL = 0;
  localparam int RS_SOFTWARE = 1;
  localparam int RS_WATCHDOG = 2;
  localparam int RS_BREAK = 3;
  localparam int RS_POWER_ON = 4;
  localparam int RS_BROWNOUT = 5;
  localparam logic [7:0] RS_IMPLEMENTED = 8'h3f;
  localparam int UC_RESET_PIN_EN = 6;
  localparam int SC_TOP_BIT = 7;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_POWER_RESET = 8'h00;
  localparam logic [7:0] RESET_SOURCE_POR = 8'h30;
  localparam logic [7:0] USER_CONFIG_RESET = 8'h40;
  localparam logic [7:0] POR_SETTLE_CYCLES = 8'h04;
  localparam int RESET_STRETCH_DEFAULT = 4;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_IDLE = 2'b01,
    PM_POWER_DOWN = 2'b10,
    PM_TOTAL_DOWN = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    ST_POWER_ON = 2'b00,
    ST_RUN = 2'b01,
    ST_RESET = 2'b10
  } seq_t;

endpackage

/* rtl/power_reset_ctrl.sv */
// Power-control registers, peripheral clock gating and reset-source sequencing.
// Assumes one 10 MHz clock, rst_n_in driven by the power-on detector, and that
// watchdog, software and break requests come from logic on the same clock.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// - Power register bits 2 and 3 are plain software flags with no effect.
// - Brownout raises an interrupt when bit 4 is set, otherwise resets.
// - Power register bit 5 set powers down and disables brownout detection.
// - Flash program/erase commands abort while brownout detection is powered down; here only bit 5 aborts them, not mode 3.
// - Bit 6 picks serial control bit 7 as mode bit or framing error.
// - Bit 7 set passes Timer 1 overflows undivided, clear halves them.
// - Power register bits 1:0 select the power-reduction mode.
// - Mode 3 is total power-down, also disabling brownout and comparator.
// - Serial clock gated by bit 1 or by either power-down mode.
// - Converter clock off when peripheral bit 4 set.
// - Comparator powered down when peripheral bit 5 set.
// - Real-time clock feed disabled when peripheral bit 7 set.
// - Shared pin is active-low reset when enabled, else digital input.
// - During power-on the shared pin always acts as reset input.
// - Only power-on overrides the pin selection; other resets leave it.
// - Pin held low at power-on keeps the device in reset.
// - Reset sources: pin, power-on, brownout, watchdog, software, UART break.
// - Each source has a flag, cleared by writing 0; several may coexist.
// - Power-on sets power-on and brownout flags, clears the others.
// - Other resets set their flag and keep uncleared flags.
// - Flag positions: pin 0, software 1, watchdog 2, break 3, power-on 4, brownout 5.
module power_reset_ctrl #(
  parameter int RESET_STRETCH = power_reset_pkg::RESET_STRETCH_DEFAULT,
  parameter bit HAS_UART = 1'b1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Power-on reset, async, active low
  input wire logic [power_reset_pkg::ADDR_W-1:0] s_axi_awaddr_in, // Write address
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write byte enables
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [power_reset_pkg::ADDR_W-1:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  input wire logic reset_pin_in, // Shared reset / input pin, async
  input wire logic brownout_detect_in, // Analog brownout level, async
  input wire logic watchdog_reset_in, // Watchdog reset request
  input wire logic software_reset_in, // Software reset request
  input wire logic break_reset_in, // UART break reset request
  input wire logic framing_error_in, // UART framing error status
  input wire logic timer1_overflow_in, // Timer 1 overflow pulse
  input wire logic flash_cmd_in, // Flash program/erase command pulse
  output logic system_reset_out, // Device reset, active high
  output logic pin_is_reset_out, // Shared pin currently acts as reset
  output logic pin_input_out, // Filtered pin level as digital input
  output logic brownout_irq_out, // Brownout interrupt request level
  output logic [1:0] power_mode_out, // Power-reduction mode
  output logic uart_clock_en_out, // UART clock enable
  output logic converter_clock_en_out, // Converter clock enable
  output logic comparator_power_out, // Comparator powered
  output logic rtc_clock_en_out, // Real-time clock feed enable
  output logic serial_mode_bit_out, // UART mode bit from serial control
  output logic framing_error_clear_out, // Pulse: software cleared framing error
  output logic uart_baud_tick_out, // Baud tick toward the UART
  output logic flash_cmd_accept_out, // Pulse: flash command accepted
  output logic flash_cmd_abort_out // Pulse: flash command aborted
);
  import power_reset_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  generate
    if (RESET_STRETCH < 1 || RESET_STRETCH > 255) begin : g_bad_stretch
      $error("RESET_STRETCH must be within 1 to 255");
    end
  endgenerate

  localparam logic [7:0] STRETCH = 8'(RESET_STRETCH);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_lvl;
    logic bod_s1;
    logic bod_s2;
    logic bod_s3;
    logic bod_lvl;
    seq_t seq;
    logic [7:0] cnt;
    logic [7:0] power_control;
    logic [7:0] peripheral_power_down;
    logic [7:0] rsrc;
    logic [7:0] ucfg;
    logic smode;
    logic fe_clear;
    logic baud_half;
    logic baud_tick;
    logic fl_ok;
    logic fl_abort;
    logic bod_irq;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t RESET_STATE = '{
    default: '0,
    pin_s1: 1'b1,
    pin_s2: 1'b1,
    pin_s3: 1'b1,
    pin_lvl: 1'b1,
    seq: ST_POWER_ON,
    cnt: POR_SETTLE_CYCLES,
    power_control: POWER_CONTROL_RESET,
    peripheral_power_down: PERIPH_POWER_RESET,
    rsrc: RESET_SOURCE_POR,
    ucfg: USER_CONFIG_RESET
  };

  state_t r;
  state_t next_r;

  // Register index decode: 0 none, 1..5 the mapped registers
  function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    if (addr[ADDR_W-1:10] == '0) begin
      unique case (addr[9:2])
        IDX_POWER_CONTROL: sel = 3'h1;
        IDX_PERIPH_POWER: sel = 3'h2;
        IDX_RESET_SOURCE: sel = 3'h3;
        IDX_SERIAL_CONTROL: sel = 3'h4;
        IDX_USER_CONFIG: sel = 3'h5;
        default: sel = 3'h0;
      endcase
    end
    return sel;
  endfunction

  // ****************************************************************
  // Combinational decode of sources and power controls
  // ****************************************************************
  power_mode_t mode;
  logic bod_on;
  logic bod_event;
  logic src_pin;
  logic src_bod;
  logic src_break;
  logic any_src;

  // Brownout is dead in total power-down as well as when powered off
  always_comb begin
    mode = power_mode_t'(r.power_control[PC_MODE_HI:PC_MODE_LO]);
    bod_on = !r.power_control[PC_BOD_OFF] && (mode != PM_TOTAL_DOWN);
    bod_event = bod_on && r.bod_lvl;
    src_pin = r.ucfg[UC_RESET_PIN_EN] && !r.pin_lvl;
    src_bod = bod_event && !r.power_control[PC_BOD_IRQ_SEL];
    src_break = HAS_UART && break_reset_in;
    any_src = src_pin || src_bod || watchdog_reset_in || software_reset_in || src_break;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [7:0] wd;

  always_comb begin
    next_r = r;
    wsel = reg_decode(r.awaddr);
    rsel = reg_decode(s_axi_araddr_in);
    wd = r.wdata;
    // Pin and brownout synchronisers; the level moves once stages 2 and 3 agree
    next_r.pin_s1 = reset_pin_in;
    next_r.pin_s2 = r.pin_s1;
    next_r.pin_s3 = r.pin_s2;
    if (r.pin_s2 == r.pin_s3) begin
      next_r.pin_lvl = r.pin_s3;
    end
    next_r.bod_s1 = brownout_detect_in;
    next_r.bod_s2 = r.bod_s1;
    next_r.bod_s3 = r.bod_s2;
    if (r.bod_s2 == r.bod_s3) begin
      next_r.bod_lvl = r.bod_s3;
    end
    next_r.fe_clear = 1'b0;
    next_r.baud_tick = 1'b0;

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata_in[7:0];
      next_r.wstrb0 = s_axi_wstrb_in[0];
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (wsel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
      if (r.wstrb0) begin
        unique case (wsel)
          3'h1: next_r.power_control = wd;
          3'h2: next_r.peripheral_power_down = wd & PP_WRITABLE;
          3'h3: next_r.rsrc = r.rsrc & wd & RS_IMPLEMENTED;
          3'h4: begin
            if (r.power_control[PC_FE_SEL]) begin
              next_r.fe_clear = !wd[SC_TOP_BIT];
            end else begin
              next_r.smode = wd[SC_TOP_BIT];
            end
          end
          3'h5: next_r.ucfg = wd;
          default: next_r.ucfg = r.ucfg;
        endcase
      end
    end
    if (r.bvalid && s_axi_bready_in) begin
      next_r.bvalid = 1'b0;
    end

    // Read channel: data is registered at the address handshake
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = (rsel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        3'h1: next_r.rdata = r.power_control;
        3'h2: next_r.rdata = r.peripheral_power_down;
        3'h3: next_r.rdata = r.rsrc;
        3'h4: next_r.rdata = {r.power_control[PC_FE_SEL] ? framing_error_in : r.smode, 7'h00};
        3'h5: next_r.rdata = r.ucfg;
        default: next_r.rdata = 8'h00;
      endcase
    end
    if (r.rvalid && s_axi_rready_in) begin
      next_r.rvalid = 1'b0;
    end

    // Reset sequencer; pin always acts as reset while in power-on
    unique case (r.seq)
      ST_POWER_ON: begin
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - 8'h01;
        end else if (r.pin_lvl) begin
          next_r.seq = ST_RUN;
        end else begin
          next_r.rsrc[RS_EXTERNAL] = 1'b1;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          next_r.seq = ST_RESET;
          next_r.cnt = STRETCH;
        end
      end
      ST_RESET: begin
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - 8'h01;
        end else if (!any_src) begin
          next_r.seq = ST_RUN;
        end
      end
      default: next_r.seq = ST_RESET;
    endcase

    // Flags set after the software write so a same-cycle set wins
    if (r.seq != ST_POWER_ON) begin
      if (src_pin) next_r.rsrc[RS_EXTERNAL] = 1'b1;
      if (software_reset_in) next_r.rsrc[RS_SOFTWARE] = 1'b1;
      if (watchdog_reset_in) next_r.rsrc[RS_WATCHDOG] = 1'b1;
      if (src_break) next_r.rsrc[RS_BREAK] = 1'b1;
      if (bod_event) next_r.rsrc[RS_BROWNOUT] = 1'b1;
    end

    // Power registers are cleared for as long as any reset is held
    if (r.seq != ST_RUN) begin
      next_r.power_control = POWER_CONTROL_RESET;
      next_r.peripheral_power_down = PERIPH_POWER_RESET;
    end

    // Brownout interrupt only when detection is live and selected
    next_r.bod_irq = bod_event && r.power_control[PC_BOD_IRQ_SEL];

    // Baud: undivided with double rate, otherwise every second overflow
    if (timer1_overflow_in) begin
      if (r.power_control[PC_DOUBLE_RATE]) begin
        next_r.baud_tick = 1'b1;
      end else begin
        next_r.baud_half = !r.baud_half;
        next_r.baud_tick = r.baud_half;
      end
    end

    // Flash commands abort only while bit 5 powers brownout detection down
    next_r.fl_ok = flash_cmd_in && !r.power_control[PC_BOD_OFF];
    next_r.fl_abort = flash_cmd_in && r.power_control[PC_BOD_OFF];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bus handshakes are combinational; one write and one read at a time
  assign s_axi_awready_out = !r.aw_got && !r.bvalid;
  assign s_axi_wready_out = !r.w_got && !r.bvalid;
  assign s_axi_bvalid_out = r.bvalid;
  assign s_axi_bresp_out = r.bresp;
  assign s_axi_arready_out = !r.rvalid;
  assign s_axi_rvalid_out = r.rvalid;
  assign s_axi_rresp_out = r.rresp;
  assign s_axi_rdata_out = {24'h000000, r.rdata};

  // Reset and pin function
  assign system_reset_out = (r.seq != ST_RUN);
  assign pin_is_reset_out = (r.seq == ST_POWER_ON) || r.ucfg[UC_RESET_PIN_EN];
  assign pin_input_out = r.pin_lvl;
  assign brownout_irq_out = r.bod_irq;

  // Clock gating; comparator is also forced off in total power-down (mode 3)
  assign power_mode_out = r.power_control[PC_MODE_HI:PC_MODE_LO];
  assign uart_clock_en_out = !r.peripheral_power_down[PP_SERIAL_OFF] && !r.power_control[PC_MODE_HI];
  assign converter_clock_en_out = !r.peripheral_power_down[PP_CONVERTER_OFF];
  assign comparator_power_out = !r.peripheral_power_down[PP_COMPARATOR_OFF] && (mode != PM_TOTAL_DOWN);
  assign rtc_clock_en_out = !r.peripheral_power_down[PP_RTC_OFF];

  // UART and flash side
  assign serial_mode_bit_out = r.smode;
  assign framing_error_clear_out = r.fe_clear;
  assign uart_baud_tick_out = r.baud_tick;
  assign flash_cmd_accept_out = r.fl_ok;
  assign flash_cmd_abort_out = r.fl_abort;

endmodule // power_reset_ctrl

/* test/power_reset_chk.sv */
// Port-level assertions for the power-control and reset-source block.
// Assumes a bind from the testbench with RESET_STRETCH handed on.
`timescale 1ns/1ps
module power_reset_chk #(
  parameter int RESET_STRETCH = 4
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Power-on reset
  input wire logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [1:0] s_axi_bresp_out, // Write response
  input wire logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  input wire logic [31:0] s_axi_rdata_out, // Read data
  input wire logic software_reset_in, // Software reset request
  input wire logic flash_cmd_in, // Flash command pulse
  input wire logic timer1_overflow_in, // Timer 1 overflow
  input wire logic system_reset_out, // Device reset
  input wire logic [1:0] power_mode_out, // Power-reduction mode
  input wire logic uart_clock_en_out, // UART clock enable
  input wire logic comparator_power_out, // Comparator powered
  input wire logic uart_baud_tick_out, // Baud tick
  input wire logic flash_cmd_accept_out, // Flash accepted
  input wire logic flash_cmd_abort_out // Flash aborted
);
  // ****************************************************************
  // Helper logic and properties
  // ****************************************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] cnt;

  // Length of the current reset pulse, so a short stretch is caught
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 8'h00;
    end else begin
      cnt <= system_reset_out ? cnt + 8'h01 : 8'h00;
    end
  end

  sequence s_sw_req;
    software_reset_in && !system_reset_out;
  endsequence

  a_sw_reset: assert property (s_sw_req |=> system_reset_out [*3])
    else $error("software request did not hold reset");
  a_reset_len: assert property ($fell(system_reset_out) |-> $past(cnt) >= RESET_STRETCH)
    else $error("reset pulse too short");
  a_regs_clear: assert property (system_reset_out |=> power_mode_out == 2'b00)
    else $error("power mode not cleared by reset");
  a_uart_gate: assert property (power_mode_out[1] |-> !uart_clock_en_out)
    else $error("uart clock running in power-down");
  a_total_down: assert property (power_mode_out == 2'b11 |-> !comparator_power_out)
    else $error("comparator powered in total power-down");
  a_flash_one: assert property (flash_cmd_in |=> flash_cmd_accept_out ^ flash_cmd_abort_out)
    else $error("flash command not answered once");
  a_flash_idle: assert property (!flash_cmd_in |=> !flash_cmd_accept_out && !flash_cmd_abort_out)
    else $error("flash answer without command");
  a_tick_idle: assert property (!timer1_overflow_in |=> !uart_baud_tick_out)
    else $error("baud tick without overflow");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
endmodule // power_reset_chk

/* test/testbench.sv */
// Self-checking bench for the power-control and reset-source block.
// Assumes the design package is compiled first; drives every port itself.
`timescale 1ns/1ps
module testbench;
  import power_reset_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, power_mode_out, rs;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic reset_pin_in, brownout_detect_in, watchdog_reset_in, software_reset_in, break_reset_in;
  logic framing_error_in, timer1_overflow_in, flash_cmd_in, system_reset_out, pin_is_reset_out;
  logic pin_input_out, brownout_irq_out, uart_clock_en_out, converter_clock_en_out;
  logic comparator_power_out, rtc_clock_en_out, serial_mode_bit_out, framing_error_clear_out;
  logic uart_baud_tick_out, flash_cmd_accept_out, flash_cmd_abort_out, smode = 1'b0;
  logic [7:0] pc, pp, rv, sm;
  int miscompares = 0, samples_checked = 0, ticks = 0, t0;

  always #50 clk_in = ~clk_in;
  // Count baud ticks so a rate can be judged over several overflows
  always @(posedge clk_in) if (uart_baud_tick_out === 1'b1) ticks <= ticks + 1;

  power_reset_ctrl #(.RESET_STRETCH(2)) u_power_reset_ctrl (.*);

  // ****************************************************************
  // Tasks and expectation functions
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr_in <= {2'b00, idx, 2'b00};
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1 && n < 100);
    rs = s_axi_bresp_out;
    if (n >= 100) miscompares++;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    int n;
    n = 0;
    s_axi_araddr_in <= {2'b00, idx, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1 && n < 100);
    d = s_axi_rdata_out[7:0];
    rs = s_axi_rresp_out;
    if (n >= 100) miscompares++;
  endtask

  // Bounded wait for the device to leave reset
  task automatic wait_run();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (system_reset_out !== 1'b0 && n < 100);
    if (n >= 100) miscompares++;
  endtask

  // One-cycle request from source k: software, watchdog, break
  task automatic fire(input int k);
    software_reset_in <= (k == 0);
    watchdog_reset_in <= (k == 1);
    break_reset_in <= (k == 2);
    @(posedge clk_in);
    {software_reset_in, watchdog_reset_in, break_reset_in} <= 3'b000;
    @(posedge clk_in);
    chk(system_reset_out, 1'b1);
    wait_run();
  endtask

  function automatic logic uart_en(input logic [7:0] c, input logic [7:0] p);
    return !p[PP_SERIAL_OFF] && !c[PC_MODE_HI];
  endfunction

  function automatic logic cmp_on(input logic [7:0] c, input logic [7:0] p);
    return !p[PP_COMPARATOR_OFF] && (c[1:0] != 2'b11);
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    // Response readies stay high, so back-to-back calls never toggle them in one step
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h2;
    {s_axi_rready_in, brownout_detect_in, watchdog_reset_in, software_reset_in} = 4'h8;
    {break_reset_in, framing_error_in, timer1_overflow_in, flash_cmd_in} = 4'h0;
    s_axi_awaddr_in = '0;
    s_axi_araddr_in = '0;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hf;
    reset_pin_in = 1'b0;
    void'($urandom(32'ha31e));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Pin held low through power-on keeps the device in reset
    repeat (20) @(posedge clk_in);
    chk(system_reset_out, 1'b1);
    reset_pin_in <= 1'b1;
    wait_run();
    rd(IDX_RESET_SOURCE, rv);
    chk(rv, 8'h31);
    rd(IDX_POWER_CONTROL, rv);
    chk(rv, POWER_CONTROL_RESET);
    rd(IDX_PERIPH_POWER, rv);
    chk(rv, PERIPH_POWER_RESET);
    wr(IDX_RESET_SOURCE, 8'h00);
    rd(IDX_RESET_SOURCE, rv);
    chk(rv, 8'h00);
    // Corner settings first, then random ones
    for (int i = 0; i < 10; i++) begin
      pc = (i == 0) ? 8'hdf : (i == 1) ? 8'h23 : 8'($urandom);
      pp = (i == 0) ? 8'hff : 8'($urandom);
      wr(IDX_POWER_CONTROL, pc);
      wr(IDX_PERIPH_POWER, pp);
      rd(IDX_POWER_CONTROL, rv);
      chk(rv, pc);
      chk(power_mode_out, pc[1:0]);
      rd(IDX_PERIPH_POWER, rv);
      chk(rv, pp & PP_WRITABLE);
      chk(uart_clock_en_out, uart_en(pc, pp));
      chk(converter_clock_en_out, !pp[PP_CONVERTER_OFF]);
      chk(comparator_power_out, cmp_on(pc, pp));
      chk(rtc_clock_en_out, !pp[PP_RTC_OFF]);
      flash_cmd_in <= 1'b1;
      @(posedge clk_in);
      flash_cmd_in <= 1'b0;
      @(posedge clk_in);
      chk({flash_cmd_accept_out, flash_cmd_abort_out}, {!pc[PC_BOD_OFF], pc[PC_BOD_OFF]});
      t0 = ticks;
      repeat (4) begin
        timer1_overflow_in <= 1'b1;
        @(posedge clk_in);
        timer1_overflow_in <= 1'b0;
        @(posedge clk_in);
      end
      @(posedge clk_in);
      chk(ticks - t0, pc[PC_DOUBLE_RATE] ? 4 : 2);
      framing_error_in <= pc[2];
      sm = 8'($urandom) & 8'h80;
      wr(IDX_SERIAL_CONTROL, sm);
      chk(framing_error_clear_out, pc[PC_FE_SEL] && !sm[7]);
      if (!pc[PC_FE_SEL]) smode = sm[7];
      rd(IDX_SERIAL_CONTROL, rv);
      chk(rv, {pc[PC_FE_SEL] ? pc[2] : smode, 7'h00});
      chk(serial_mode_bit_out, smode);
    end
    rd(8'h10, rv);
    chk({rs, rv}, {RESP_SLVERR, 8'h00});
    // Brownout: interrupt, then ignored while powered down, then reset
    wr(IDX_POWER_CONTROL, 8'h10);
    brownout_detect_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk({brownout_irq_out, system_reset_out}, 2'b10);
    wr(IDX_POWER_CONTROL, 8'h20);
    repeat (8) @(posedge clk_in);
    chk({brownout_irq_out, system_reset_out}, 2'b00);
    // Total power-down with reset selected must still ignore the detector
    wr(IDX_POWER_CONTROL, 8'h03);
    repeat (8) @(posedge clk_in);
    chk(system_reset_out, 1'b0);
    brownout_detect_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    wr(IDX_RESET_SOURCE, 8'h00);
    wr(IDX_POWER_CONTROL, 8'h0c);
    brownout_detect_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(system_reset_out, 1'b1);
    brownout_detect_in <= 1'b0;
    wait_run();
    rd(IDX_POWER_CONTROL, rv);
    chk(rv, 8'h00);
    for (int k = 0; k < 3; k++) fire(k);
    rd(IDX_RESET_SOURCE, rv);
    chk(rv, 8'h2e);
    // Pin as reset, then as plain input
    reset_pin_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(system_reset_out, 1'b1);
    reset_pin_in <= 1'b1;
    wait_run();
    chk({pin_is_reset_out, pin_input_out}, 2'b11);
    wr(IDX_USER_CONFIG, 8'h00);
    chk(pin_is_reset_out, 1'b0);
    reset_pin_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({system_reset_out, pin_input_out}, 2'b00);
    rd(IDX_RESET_SOURCE, rv);
    chk(rv, 8'h2f);
    final_report();
  end

  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    final_report();
  end
endmodule // testbench

bind power_reset_ctrl power_reset_chk #(.RESET_STRETCH(RESET_STRETCH)) u_power_reset_chk (.*);
